// *** design/dme_eeprom.sv ***
// dual mode serial eeprom: transmit-only stream and two-wire slave
`timescale 1ns/100ps
module dme_eeprom #(
   parameter int unsigned WR_CYC = dme_pkg::WR_CYC
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_tx_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   output dme_pkg::dme_od_t o_sda,
   output logic o_i2c_mode
);
   import dme_pkg::*;

   localparam int unsigned TW = $clog2(WR_CYC + 1);

   // ==========================================================
   // storage
   logic [WORD_W-1:0] mem [DEPTH];
   logic [WORD_W-1:0] pbuf [PAGE];

   // ==========================================================
   // pin synchronisers (main domain)
   logic [1:0] scl_sy;
   logic [1:0] sda_sy;
   logic scl_d;
   logic sda_d;
   logic i2c_mode;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (i_ce) begin
         scl_sy <= {scl_sy[0], i_scl};
         sda_sy <= {sda_sy[0], i_sda};
         scl_d <= scl_sy[1];
         sda_d <= sda_sy[1];
      end
   end

   wire scl = scl_sy[1];
   wire sda = sda_sy[1];
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   // bus conditions only exist once in two-wire mode
   wire start_c = i2c_mode & scl & scl_d & sda_d & ~sda;
   wire stop_c = i2c_mode & scl & scl_d & ~sda_d & sda;

   // ==========================================================
   // mode latch
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         i2c_mode <= 1'b0;
      end else if (i_ce && scl_fall) begin
         i2c_mode <= 1'b1;
      end
   end

   // ==========================================================
   // transmit-only clock domain: bit pointer, gray coded
   logic [1:0] mode_ly;
   logic [1:0] ce_ly;
   logic [PTR_W-1:0] tx_bin;
   logic [PTR_W-1:0] tx_gray;

   wire [PTR_W-1:0] next_tx_bin = tx_bin + PTR_W'(1);
   wire [PTR_W-1:0] next_tx_gray = next_tx_bin ^ (next_tx_bin >> 1);
   wire tx_step = ce_ly[1] & ~mode_ly[1];

   always_ff @(posedge i_tx_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_ly <= 2'h0;
         // enable assumed high at power-up so the first link edge already steps
         ce_ly <= 2'h3;
         tx_bin <= '0;
         tx_gray <= '0;
      end else begin
         mode_ly <= {mode_ly[0], i2c_mode};
         ce_ly <= {ce_ly[0], i_ce};
         if (tx_step) begin
            tx_bin <= next_tx_bin;
            tx_gray <= next_tx_gray;
         end
      end
   end

   // ==========================================================
   // pointer crossing back to main domain
   logic [PTR_W-1:0] g_sy0;
   logic [PTR_W-1:0] g_sy1;
   logic [PTR_W-1:0] g_bin;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         g_sy0 <= '0;
         g_sy1 <= '0;
      end else if (i_ce) begin
         g_sy0 <= tx_gray;
         g_sy1 <= g_sy0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < PTR_W; gi++) begin : g_gray2bin
         assign g_bin[gi] = ^g_sy1[PTR_W-1:gi];
      end
   endgenerate

   // msb of each byte goes out first
   wire [AW-1:0] tx_byte = g_bin[PTR_W-1:PAGE_AW];
   wire [2:0] tx_sel = 3'h7 - g_bin[2:0];
   wire tx_bit = mem[tx_byte][tx_sel];

   // ==========================================================
   // two-wire slave
   dme_state_t state;
   logic [3:0] bitcnt;
   logic [WORD_W-1:0] shreg;
   logic ack_ph;
   logic drive_low;
   logic [AW-1:0] word_addr;
   logic [AW-1:0] paddr;
   logic [3:0] pcnt;
   logic [PAGE_AW-1:0] cidx;
   logic [TW-1:0] timer;

   wire busy = (state == ST_PROG) || (state == ST_COMMIT);
   wire byte_done = scl_fall & ~ack_ph & (bitcnt == BYTE_BITS);
   wire dev_hit = shreg[7:4] == DEV_CODE;
   wire dev_rd = shreg[0];
   wire page_room = pcnt < PAGE_FULL;
   wire [WORD_W-1:0] rd_word = mem[word_addr];
   wire [AW-1:0] next_addr = word_addr + AW'(1);
   wire pbuf_we = i_ce & ~busy & ~start_c & ~stop_c & byte_done
      & (state == ST_WDATA) & page_room;
   wire mem_we = i_ce & (state == ST_COMMIT);
   wire [AW-1:0] commit_addr = paddr + AW'(cidx);
   wire timer_done = timer == TW'(WR_CYC - 1);
   wire commit_last = {1'b0, cidx} == (pcnt - 4'h1);

   always_ff @(posedge i_clk) begin
      if (pbuf_we) begin
         pbuf[pcnt[PAGE_AW-1:0]] <= shreg;
      end
      if (mem_we) begin
         mem[commit_addr] <= pbuf[cidx];
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= ST_IDLE;
         bitcnt <= '0;
         shreg <= '0;
         ack_ph <= 1'b0;
         drive_low <= 1'b0;
         word_addr <= '0;
         paddr <= '0;
         pcnt <= '0;
         cidx <= '0;
         timer <= '0;
      end else if (i_ce) begin
         case (state)
            ST_PROG: begin
               // bus ignored: no acknowledge while programming
               timer <= timer + TW'(1);
               if (timer_done) begin
                  state <= ST_COMMIT;
                  cidx <= '0;
               end
            end
            ST_COMMIT: begin
               cidx <= cidx + 3'h1;
               if (commit_last) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               if (start_c) begin
                  // repeated start keeps word_addr for random reads
                  state <= ST_DEV;
                  bitcnt <= '0;
                  ack_ph <= 1'b0;
                  drive_low <= 1'b0;
               end else if (stop_c) begin
                  ack_ph <= 1'b0;
                  drive_low <= 1'b0;
                  timer <= '0;
                  if (state == ST_WDATA && pcnt != 4'h0) begin
                     state <= ST_PROG;
                  end else begin
                     state <= ST_IDLE;
                  end
               end else if (scl_rise) begin
                  if (ack_ph) begin
                     if (state == ST_RDATA && sda) begin
                        state <= ST_IDLE;
                     end
                  end else begin
                     shreg <= {shreg[6:0], sda};
                     bitcnt <= bitcnt + 4'h1;
                  end
               end else if (scl_fall) begin
                  if (ack_ph) begin
                     ack_ph <= 1'b0;
                     bitcnt <= '0;
                     drive_low <= 1'b0;
                     if (state == ST_RDATA) begin
                        shreg <= rd_word;
                        drive_low <= ~rd_word[7];
                        word_addr <= next_addr;
                     end
                  end else if (bitcnt == BYTE_BITS) begin
                     ack_ph <= 1'b1;
                     drive_low <= 1'b0;
                     case (state)
                        ST_DEV: begin
                           if (dev_hit) begin
                              drive_low <= 1'b1;
                              state <= dev_rd ? ST_RDATA : ST_WADDR;
                           end else begin
                              state <= ST_IDLE;
                           end
                        end
                        ST_WADDR: begin
                           drive_low <= 1'b1;
                           word_addr <= shreg[AW-1:0];
                           paddr <= shreg[AW-1:0];
                           pcnt <= '0;
                           state <= ST_WDATA;
                        end
                        ST_WDATA: begin
                           // bytes past a full page are refused
                           if (page_room) begin
                              drive_low <= 1'b1;
                              pcnt <= pcnt + 4'h1;
                              word_addr <= next_addr;
                           end
                        end
                        default: begin
                           drive_low <= 1'b0;
                        end
                     endcase
                  end else if (state == ST_RDATA) begin
                     drive_low <= ~shreg[7];
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // outputs
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sda <= '{oe: 1'b0, out: 1'b0};
         o_i2c_mode <= 1'b0;
      end else if (i_ce) begin
         // open drain: only ever pulls low
         o_sda <= '{oe: (i2c_mode ? drive_low : ~tx_bit), out: 1'b0};
         o_i2c_mode <= i2c_mode;
      end
   end
endmodule

// *** design/dme_pkg.sv ***
// constants, states and pin carrier for the dual mode serial eeprom
package dme_pkg;
   // ==========================================================
   // array geometry
   localparam int unsigned MEM_BITS = 1024;
   localparam int unsigned WORD_W = 8;
   localparam int unsigned DEPTH = MEM_BITS / WORD_W;
   localparam int unsigned AW = 7;
   localparam int unsigned PTR_W = 10;
   localparam int unsigned PAGE = 8;
   localparam int unsigned PAGE_AW = 3;
   // ==========================================================
   // bus framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] PAGE_FULL = 4'h8;
   // device type code: value is arbitrary
   localparam logic [3:0] DEV_CODE = 4'ha;
   // ==========================================================
   // timing
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned T_WR_US = 10000;
   localparam int unsigned WR_CYC = T_WR_US * CLK_MHZ;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_WADDR,
      ST_WDATA,
      ST_RDATA,
      ST_PROG,
      ST_COMMIT
   } dme_state_t;

   typedef struct packed {
      logic oe;
      logic out;
   } dme_od_t;
endpackage

// *** sim/dme_eeprom_assertions.sv ***
// pin-level assertions for the dual mode serial eeprom
`timescale 1ns/100ps
module dme_eeprom_assertions #(
   parameter int unsigned WR_CYC = dme_pkg::WR_CYC
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_tx_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   input dme_pkg::dme_od_t o_sda,
   input wire logic o_i2c_mode
);
   import dme_pkg::*;
   // ==========
   // properties
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   property p_pwr_up; $rose(i_rstn) |-> !o_i2c_mode; endproperty
   property p_stay; o_i2c_mode |=> o_i2c_mode; endproperty
   property p_switch; $fell(i_scl) && i_ce |-> ##[1:6] o_i2c_mode; endproperty
   property p_no_early; (i_scl && !o_i2c_mode) [*3] |=> !o_i2c_mode; endproperty
   // stream bit lands well inside the high half of the link clock
   property p_stream; !o_i2c_mode && $changed(o_sda.oe) && $past(i_rstn, 4) |-> i_tx_clk;
   endproperty
   property p_bus_hold; o_i2c_mode && $changed(o_sda.oe) |-> !i_scl; endproperty
   property p_ack_hold; o_i2c_mode && $rose(o_sda.oe) |=> o_sda.oe [*8]; endproperty
   property p_od; o_sda.out == 1'b0; endproperty
   // ==========
   // checks
   a_pwr_up: assert property (p_pwr_up) else $error("mode at power-up");
   a_stay: assert property (p_stay) else $error("mode lost");
   a_switch: assert property (p_switch) else $error("no switch");
   a_no_early: assert property (p_no_early) else $error("early switch");
   a_stream: assert property (p_stream) else $error("stream bit moved");
   a_bus_hold: assert property (p_bus_hold) else $error("data moved, clock high");
   a_ack_hold: assert property (p_ack_hold) else $error("low bit short");
   a_od: assert property (p_od) else $error("drives high");
   cover property ($rose(o_i2c_mode));
   cover property (o_i2c_mode && $rose(o_sda.oe));
   cover property (!o_i2c_mode && $changed(o_sda.oe));
endmodule
bind dme_eeprom dme_eeprom_assertions #(.WR_CYC(WR_CYC)) dme_eeprom_assertions_i (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_tx_clk(i_tx_clk),
   .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_i2c_mode(o_i2c_mode)
);

// *** sim/dme_host.sv ***
// two-wire bus master model for the eeprom bench
`timescale 1ns/100ps
module dme_host (
   input wire logic i_clk,
   input wire logic i_oe,
   output logic o_scl,
   output logic o_sda
);
   // ==========
   // quarter bit of 79 cycles keeps the clock just below 400 kHz
   localparam int Q = 79;
   logic pull = 1'b0;
   initial o_scl = 1'b1;
   // pull-up wins unless a party pulls low
   assign o_sda = ~(pull | i_oe);
   // master alone moves the clock; the slave may also pull data low
   task automatic ph(input logic c, input logic p);
      repeat (Q) @(posedge i_clk);
      o_scl <= c;
      pull <= p;
   endtask
   task automatic xfer(input logic b, output logic r);
      ph(1'b0, ~b);
      ph(1'b1, ~b);
      repeat (Q) @(posedge i_clk);
      r = o_sda;
      ph(1'b0, ~b);
   endtask
   task automatic start;
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
      ph(1'b0, 1'b1);
   endtask
   task automatic stop;
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(d[i], r);
      end
      xfer(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(1'b1, r);
         d[i] = r;
      end
      xfer(last, r);
   endtask
endmodule

// *** sim/tb_dme_eeprom.sv ***
// self-checking bench for the dual mode serial eeprom
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_dme_eeprom;
   import dme_pkg::*;
   // ==========
   // pins and counters
   localparam int WRC = 5000;
   localparam logic [7:0] DEV_W = {DEV_CODE, 4'h0};
   localparam logic [7:0] DEV_R = {DEV_CODE, 4'h1};
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_ce = 1'b1;
   logic i_tx_clk = 1'b0;
   logic scl;
   logic sda;
   logic ack;
   logic [7:0] d;
   dme_od_t o_sda;
   logic o_i2c_mode;
   int errors = 0;
   int total_checks = 0;
   always #4 i_clk = ~i_clk;
   dme_eeprom #(.WR_CYC(WRC)) dme_eeprom_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
      .i_tx_clk(i_tx_clk), .i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_i2c_mode(o_i2c_mode));
   dme_host dme_host_i (.i_clk(i_clk), .i_oe(o_sda.oe), .o_scl(scl), .o_sda(sda));
   function automatic logic [7:0] dat(input int k);
      return 8'h5a + 8'h13 * k[7:0];
   endfunction
   task automatic txp;
      #62.5 i_tx_clk = 1'b1;
      #62.5 i_tx_clk = 1'b0;
   endtask
   // link clock needs edges too while reset is held
   task automatic power;
      @(posedge i_clk) i_rstn <= 1'b0;
      repeat (2) txp();
      @(posedge i_clk) i_rstn <= 1'b1;
      repeat (4) @(posedge i_clk);
   endtask
   // ==========
   // scenarios
   task automatic t_switch;
      `CHK(o_i2c_mode, 1'b0)
      dme_host_i.ph(1'b0, 1'b0);
      repeat (8) @(posedge i_clk);
      `CHK(o_i2c_mode, 1'b1)
      repeat (3) txp();
      `CHK(o_i2c_mode, 1'b1)
   endtask
   task automatic t_page;
      dme_host_i.start();
      dme_host_i.wr(DEV_W, ack);
      dme_host_i.wr(8'h7e, ack);
      for (int k = 0; k < 9; k++) begin
         dme_host_i.wr(dat(k), ack);
         `CHK(ack, k < 8)
      end
      dme_host_i.stop();
      dme_host_i.start();
      dme_host_i.wr(DEV_W, ack);
      `CHK(ack, 1'b0)
      dme_host_i.stop();
      repeat (WRC) @(posedge i_clk);
   endtask
   task automatic t_read;
      dme_host_i.start();
      dme_host_i.wr(DEV_W, ack);
      `CHK(ack, 1'b1)
      dme_host_i.wr(8'h7e, ack);
      dme_host_i.start();
      dme_host_i.wr(DEV_R, ack);
      for (int k = 0; k < 3; k++) begin
         dme_host_i.rd(k == 2, d);
         `CHK(d, dat(k))
      end
      dme_host_i.stop();
      dme_host_i.start();
      dme_host_i.wr(DEV_R, ack);
      dme_host_i.rd(1'b1, d);
      `CHK(d, dat(3))
      dme_host_i.stop();
   endtask
   task automatic t_stream;
      logic [15:0] e;
      e = {dat(2), dat(3)};
      power();
      `CHK(o_i2c_mode, 1'b0)
      for (int i = 15; i >= 0; i--) begin
         `CHK(sda, e[i])
         txp();
      end
      repeat (1008) txp();
      `CHK(sda, e[15])
   endtask
   task automatic report_and_stop;
      if (errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      power();
      t_switch();
      t_page();
      t_read();
      t_stream();
      report_and_stop();
   end
   initial begin
      repeat (99000) @(posedge i_clk);
      errors++;
      report_and_stop();
   end
endmodule
